/* ecw_regs.sv */
// Purpose: Extended config window and error capability header / uncorrectable status
// Assumes: One request per cycle, local reads answered one cycle later, forwarded window reads two; reads have no side effects
// Notes:   Window accesses leave through a forwarded port; status survives port reset
// Summary of operation
// - Window address bits 7:2 hold register number selecting the target.
// - Window address bits 11:8 hold extended register number for extended space.
// - Window data read returns current value of the selected config register.
// - Window data write updates the selected register, nothing stored locally.
// - Window access byte enables are passed unchanged to the forwarded access.
// - Window pointing at window data: reads give zero, writes are dropped.
// - SMBus accesses to window data read zero and writes do nothing.
// - Capability header bits 15:0 read identifier 0x1.
// - Capability header bits 19:16 read version 0x1.
// - Status bit 0 is obsolete and never set by hardware.
// - Status bit 4 sets on data link protocol error.
// - Status bit 5 sets on surprise link-down.
// - Status bit 12 sets on received poisoned packet.
// - Status bit 13 sets on flow control protocol error.
// - Status bit 14, completion time-out, always reads zero.
// - Status bit 15, completer abort, always reads zero.
// - Status bit 16 sets on unexpected completion.
// - Status bit 17 sets on receiver overflow.
// - Status bit 18 sets on malformed packet.
// - Status bit 19 sets on end-to-end CRC error.
// - Status bit 20 sets on unsupported request.
`timescale 1ns/1ps
`default_nettype none
module ecw_regs (
   // Clock and resets
   input  wire logic              clk_in,
   input  wire logic              resetn_in,
   input  wire logic              por_resetn_in,
   // Configuration request and answer
   input  wire ecw_pkg::ecw_req_t req_in,
   output var  logic              rvalid_out,
   output var  logic [31:0]       rdata_out,
   // Forwarded access to the rest of config space
   output var  ecw_pkg::ecw_req_t fwd_out,
   input  wire logic [31:0]       fwd_rdata_in,
   // Error events
   input  wire ecw_pkg::ecw_evt_t evt_in,
   // Register views
   output var  logic [31:0]       win_addr_out,
   output var  logic [31:0]       unc_status_out
);
   logic [31:0]       win_addr_r, win_addr_nxt;
   logic [11:0]       next_ptr_r, next_ptr_nxt;
   logic [31:0]       unc_stat_r, unc_stat_nxt;
   logic              rvalid_r, rvalid_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              fwd_pend_r, fwd_pend_nxt;
   ecw_pkg::ecw_req_t fwd_r, fwd_nxt;
   logic [31:0]       evt_bits;
   logic [31:0]       be_mask;
   logic [31:0]       local_rdata;
   logic [11:0]       target;
   logic              local_hit;
   logic              win_hit;

   // Byte enables expanded to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_be
         assign be_mask[gi*8 +: 8] = {8{req_in.be[gi]}};
      end
   endgenerate

   always_comb begin
      evt_bits                          = '0;
      evt_bits[ecw_pkg::EV_LINK_PROT]   = evt_in.link_prot;
      evt_bits[ecw_pkg::EV_SURPRISE_DN] = evt_in.surprise_dn;
      evt_bits[ecw_pkg::EV_POISONED]    = evt_in.poisoned;
      evt_bits[ecw_pkg::EV_FC_PROT]     = evt_in.fc_prot;
      evt_bits[ecw_pkg::EV_UNEXP_CPL]   = evt_in.unexp_cpl;
      evt_bits[ecw_pkg::EV_RX_OVERFLOW] = evt_in.rx_overflow;
      evt_bits[ecw_pkg::EV_MALFORMED]   = evt_in.malformed;
      evt_bits[ecw_pkg::EV_ECRC]        = evt_in.ecrc;
      evt_bits[ecw_pkg::EV_UNSUP_REQ]   = evt_in.unsup_req;
   end

   // Window target byte address from register and extended numbers
   assign target = {win_addr_r[ecw_pkg::EXT_NUM_MSB:ecw_pkg::EXT_NUM_LSB],
                    win_addr_r[ecw_pkg::REG_NUM_MSB:ecw_pkg::REG_NUM_LSB], 2'b00};
   assign win_hit = req_in.valid && (req_in.addr == ecw_pkg::WIN_DATA_OFS);

   always_comb begin
      local_hit   = 1'b1;
      local_rdata = '0;
      unique case (req_in.addr)
         ecw_pkg::WIN_ADDR_OFS: local_rdata = win_addr_r;
         ecw_pkg::ERR_CAP_OFS:  local_rdata = {next_ptr_r, ecw_pkg::CAP_VER_VAL,
                                              ecw_pkg::CAP_ID_VAL};
         ecw_pkg::UNC_STAT_OFS: local_rdata = unc_stat_r;
         default:               local_hit   = 1'b0;
      endcase
   end

   always_comb begin
      win_addr_nxt = win_addr_r;
      next_ptr_nxt = next_ptr_r;
      unc_stat_nxt = unc_stat_r;
      rvalid_nxt   = 1'b0;
      rdata_nxt    = rdata_r;
      fwd_pend_nxt = 1'b0;
      fwd_nxt      = '0;
      if (req_in.valid && req_in.write) begin
         unique case (req_in.addr)
            ecw_pkg::WIN_ADDR_OFS:
               win_addr_nxt = ((win_addr_r & ~be_mask) | (req_in.wdata & be_mask))
                              & ecw_pkg::WIN_ADDR_MASK;
            ecw_pkg::ERR_CAP_OFS: begin
               // Pointer is locked from the link side; only SMBus may retarget it
               if (req_in.smbus) begin
                  next_ptr_nxt = (next_ptr_r & ~be_mask[31:20]) |
                                 (req_in.wdata[31:20] & be_mask[31:20]);
               end
            end
            ecw_pkg::UNC_STAT_OFS:
               unc_stat_nxt = unc_stat_r &
                              ~(req_in.wdata & be_mask & ecw_pkg::UNC_W1C_MASK);
            default: begin
            end
         endcase
      end
      // Set after clear so an event in the clearing cycle wins
      unc_stat_nxt = unc_stat_nxt | (evt_bits & ecw_pkg::UNC_SET_MASK);
      if (req_in.valid) begin
         if (win_hit && !req_in.smbus && target != ecw_pkg::WIN_DATA_OFS) begin
            fwd_nxt       = req_in;
            fwd_nxt.addr  = target;
            fwd_nxt.smbus = 1'b0;
            fwd_pend_nxt  = !req_in.write;
         end else begin
            // Self-pointing or SMBus window access reads zero, write dropped
            rvalid_nxt = !req_in.write;
            rdata_nxt  = (local_hit && !win_hit) ? local_rdata : '0;
         end
      end
      if (fwd_pend_r) begin
         rvalid_nxt = 1'b1;
         rdata_nxt  = fwd_rdata_in;
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         win_addr_r <= ecw_pkg::WIN_ADDR_RST;
         next_ptr_r <= ecw_pkg::NEXT_PTR_RST;
         rvalid_r   <= 1'b0;
         rdata_r    <= '0;
         fwd_pend_r <= 1'b0;
         fwd_r      <= '0;
      end else begin
         win_addr_r <= win_addr_nxt;
         next_ptr_r <= next_ptr_nxt;
         rvalid_r   <= rvalid_nxt;
         rdata_r    <= rdata_nxt;
         fwd_pend_r <= fwd_pend_nxt;
         fwd_r      <= fwd_nxt;
      end
   end

   // Sticky status is reset by power-on reset only, not by port reset
   always_ff @(posedge clk_in or negedge por_resetn_in) begin
      if (!por_resetn_in) begin
         unc_stat_r <= ecw_pkg::UNC_STAT_RST;
      end else begin
         unc_stat_r <= unc_stat_nxt;
      end
   end

   assign rvalid_out     = rvalid_r;
   assign rdata_out      = rdata_r;
   assign fwd_out        = fwd_r;
   assign win_addr_out   = win_addr_r;
   assign unc_status_out = unc_stat_r;

   stat_set_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.poisoned |=> unc_stat_r[ecw_pkg::EV_POISONED])
      else $error("poisoned event not latched");
   stat_hold_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      (unc_stat_r[ecw_pkg::EV_ECRC] && !(req_in.valid && req_in.write))
      |=> unc_stat_r[ecw_pkg::EV_ECRC])
      else $error("status bit dropped without write");
   stat_w1c_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      (req_in.valid && req_in.write && req_in.addr == ecw_pkg::UNC_STAT_OFS &&
       req_in.be[0] && req_in.wdata[4] && !evt_in.link_prot) |=> !unc_stat_r[4])
      else $error("write one did not clear");
   stat_zero_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      !unc_stat_r[14] && !unc_stat_r[15] && !unc_stat_r[0])
      else $error("fixed zero status bit set");
   cap_hdr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (req_in.valid && !req_in.write && req_in.addr == ecw_pkg::ERR_CAP_OFS)
      |=> rvalid_r && rdata_r[19:0] == 20'h1_0001)
      else $error("capability header wrong");
   fwd_addr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && !req_in.smbus && target != ecw_pkg::WIN_DATA_OFS)
      |=> fwd_r.valid && fwd_r.addr == $past(target) && fwd_r.be == $past(req_in.be))
      else $error("forwarded access wrong");
   fwd_data_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && !req_in.write && !req_in.smbus && target != ecw_pkg::WIN_DATA_OFS)
      |=> ##1 rvalid_r && rdata_r == $past(fwd_rdata_in))
      else $error("window read data wrong");
   smb_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && req_in.smbus && !req_in.write) |=> rvalid_r && rdata_r == '0 && !fwd_r.valid)
      else $error("smbus window read not zero");
   self_zero_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && target == ecw_pkg::WIN_DATA_OFS) |=> !fwd_r.valid)
      else $error("self window access forwarded");

   // One check per event source except poisoned, checked by stat_set_a above; a crossed wire in the mapping shows here
   stat_link_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.link_prot |=> unc_stat_r[ecw_pkg::EV_LINK_PROT])
      else $error("link protocol event not latched");

   stat_surp_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.surprise_dn |=> unc_stat_r[ecw_pkg::EV_SURPRISE_DN])
      else $error("surprise down event not latched");

   stat_fc_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.fc_prot |=> unc_stat_r[ecw_pkg::EV_FC_PROT])
      else $error("flow control event not latched");

   stat_cpl_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.unexp_cpl |=> unc_stat_r[ecw_pkg::EV_UNEXP_CPL])
      else $error("unexpected completion not latched");

   stat_ovf_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.rx_overflow |=> unc_stat_r[ecw_pkg::EV_RX_OVERFLOW])
      else $error("receiver overflow not latched");

   stat_mal_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.malformed |=> unc_stat_r[ecw_pkg::EV_MALFORMED])
      else $error("malformed packet not latched");

   stat_ecrc_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.ecrc |=> unc_stat_r[ecw_pkg::EV_ECRC])
      else $error("crc event not latched");

   stat_ur_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      evt_in.unsup_req |=> unc_stat_r[ecw_pkg::EV_UNSUP_REQ])
      else $error("unsupported request not latched");

   // Bits without a hardware source, reserved ones included, stay zero
   stat_ro_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      (unc_stat_r & ~ecw_pkg::UNC_SET_MASK) == 32'h0)
      else $error("status bit without source set");

   stat_clr_a: assert property (@(posedge clk_in) disable iff (!por_resetn_in)
      (req_in.valid && req_in.write && req_in.addr == ecw_pkg::UNC_STAT_OFS &&
       req_in.be == 4'hF && req_in.wdata == 32'hFFFF_FFFF && evt_in == '0)
      |=> unc_stat_r == 32'h0)
      else $error("full clear left bits set");

   stat_rd_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (req_in.valid && !req_in.write && req_in.addr == ecw_pkg::UNC_STAT_OFS && !fwd_pend_r)
      |=> rvalid_r && rdata_r == $past(unc_stat_r))
      else $error("status read wrong");

   // Window address register and its forwarding
   win_rsvd_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_addr_r & ~ecw_pkg::WIN_ADDR_MASK) == 32'h0)
      else $error("window address reserved bits set");

   win_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (req_in.valid && !req_in.write && req_in.addr == ecw_pkg::WIN_ADDR_OFS && !fwd_pend_r)
      |=> rvalid_r && rdata_r == $past(win_addr_r))
      else $error("window address read wrong");

   win_keep_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && req_in.write) |=> $stable(win_addr_r))
      else $error("window data write changed window address");

   fwd_wr_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && req_in.write && !req_in.smbus && target != ecw_pkg::WIN_DATA_OFS)
      |=> fwd_r.write && fwd_r.wdata == $past(req_in.wdata))
      else $error("forwarded write data wrong");

   fwd_rd_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && !req_in.write && !req_in.smbus && target != ecw_pkg::WIN_DATA_OFS)
      |=> fwd_r.valid && !fwd_r.write && !fwd_r.smbus)
      else $error("forwarded read malformed");

   fwd_idle_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      !req_in.valid |=> !fwd_r.valid)
      else $error("forward without request");

   smb_drop_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && req_in.smbus && req_in.write) |=> !fwd_r.valid)
      else $error("smbus window write forwarded");

   self_read_a: assert property (@(posedge clk_in) disable iff (!resetn_in)
      (win_hit && !req_in.write && target == ecw_pkg::WIN_DATA_OFS && !fwd_pend_r)
      |=> rvalid_r && rdata_r == 32'h0)
      else $error("self window read not zero");
endmodule
`default_nettype wire

/* ecw_pkg.sv */
// Purpose: Shared constants and carriers for the extended config window and error status block
// Assumes: Dword-wide config register port with byte enables, offsets are byte addresses
// Notes:   Status layout follows the uncorrectable error status register
package ecw_pkg;
   localparam logic [11:0] WIN_ADDR_OFS   = 12'h0F8;
   localparam logic [11:0] WIN_DATA_OFS   = 12'h0FC;
   localparam logic [11:0] ERR_CAP_OFS    = 12'h100;
   localparam logic [11:0] UNC_STAT_OFS   = 12'h104;
   localparam int          REG_NUM_LSB    = 2;
   localparam int          REG_NUM_MSB    = 7;
   localparam int          EXT_NUM_LSB    = 8;
   localparam int          EXT_NUM_MSB    = 11;
   localparam logic [31:0] WIN_ADDR_MASK  = 32'h0000_0FFC;
   localparam logic [31:0] WIN_ADDR_RST   = 32'h0000_0000;
   localparam logic [15:0] CAP_ID_VAL     = 16'h0001;
   localparam logic [3:0]  CAP_VER_VAL    = 4'h1;
   localparam logic [11:0] NEXT_PTR_RST   = 12'h200;
   localparam logic [31:0] UNC_STAT_RST   = 32'h0000_0000;
   // Bits that hardware may set; 0, 14, 15 and reserved never set
   localparam logic [31:0] UNC_SET_MASK   = 32'h001F_3030;
   // Bit 0 is clearable but has no hardware source
   localparam logic [31:0] UNC_W1C_MASK   = 32'h001F_3031;
   localparam int          EV_LINK_PROT   = 4;
   localparam int          EV_SURPRISE_DN = 5;
   localparam int          EV_POISONED    = 12;
   localparam int          EV_FC_PROT     = 13;
   localparam int          EV_UNEXP_CPL   = 16;
   localparam int          EV_RX_OVERFLOW = 17;
   localparam int          EV_MALFORMED   = 18;
   localparam int          EV_ECRC        = 19;
   localparam int          EV_UNSUP_REQ   = 20;

   // One configuration access, from the link or from SMBus
   typedef struct packed {
      logic        valid;
      logic        write;
      logic        smbus;
      logic [11:0] addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } ecw_req_t;

   // Error events from the port, one pulse each
   typedef struct packed {
      logic link_prot;
      logic surprise_dn;
      logic poisoned;
      logic fc_prot;
      logic unexp_cpl;
      logic rx_overflow;
      logic malformed;
      logic ecrc;
      logic unsup_req;
   } ecw_evt_t;
endpackage

/* ecw_cfg_model.sv */
// Purpose: Config space behind the window's forwarded port
// Assumes: Read data is wanted in the cycle fwd valid is high
// Notes:   Shows zero when idle: the idle pattern starts at zero and is negated each cycle, so it never changes
`timescale 1ns/1ps
`default_nettype none
module ecw_cfg_model (
   input  wire logic              clk_in,
   input  wire ecw_pkg::ecw_req_t fwd_in,
   output var  logic [31:0]       fwd_rdata_out
);
   logic [31:0] mem [1024];
   logic [31:0] junk_r;
   initial begin
      junk_r = 32'h0000_0000;
      for (int i = 0; i < 1024; i++) mem[i] = 32'h0;
   end
   always @(posedge clk_in) begin
      junk_r <= ~junk_r + 32'h1;
      if (fwd_in.valid && fwd_in.write) begin
         for (int b = 0; b < 4; b++)
            if (fwd_in.be[b]) mem[fwd_in.addr[11:2]][8*b+:8] <= fwd_in.wdata[8*b+:8];
      end
   end
   assign fwd_rdata_out = (fwd_in.valid && !fwd_in.write) ? mem[fwd_in.addr[11:2]] : junk_r;
endmodule
`default_nettype wire

/* ecw_regs_tb_top.sv */
// Purpose: Self-checking bench for the config window and error status block
// Assumes: Requests driven 1 ns after the rising edge
// Notes:   Window targets kept away from the block's own offsets
`timescale 1ns/1ps
`default_nettype none
module ecw_regs_tb_top;
   logic              clk_in = 1'b0;
   logic              resetn_in = 1'b0;
   logic              por_n = 1'b0;
   ecw_pkg::ecw_req_t req = '0;
   ecw_pkg::ecw_req_t fwd;
   ecw_pkg::ecw_evt_t evt = '0;
   logic [31:0]       rdata, frd, waddr, stat, v, d, w, es = 0, em [1024];
   logic [11:0]       t;
   logic              rvalid;
   int                mismatches = 0, n_compared = 0;
   int                evb [9] = '{20, 19, 18, 17, 16, 13, 12, 5, 4};
   logic [31:0]       seed = 32'h0000_8740;
   ecw_regs u_dut (.clk_in(clk_in), .resetn_in(resetn_in), .por_resetn_in(por_n),
      .req_in(req), .rvalid_out(rvalid), .rdata_out(rdata), .fwd_out(fwd),
      .fwd_rdata_in(frd), .evt_in(evt), .win_addr_out(waddr), .unc_status_out(stat));
   ecw_cfg_model u_cfg (.clk_in(clk_in), .fwd_in(fwd), .fwd_rdata_out(frd));
   initial forever #5 clk_in = ~clk_in;
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
      n_compared++;
      if (g !== e) begin
         $display("BAD %0t %s got %h want %h", $time, m, g, e);
         mismatches++;
      end
   endtask
   task automatic send(input logic w, s, input logic [11:0] a, input logic [3:0] b,
                       input logic [31:0] wd);
      @(posedge clk_in);
      #1 req = '{valid: 1'b1, write: w, smbus: s, addr: a, be: b, wdata: wd};
      @(posedge clk_in);
      #1 req.valid = 1'b0;
   endtask
   task automatic rd(input logic s, input logic [11:0] a, input logic [31:0] e);
      send(1'b0, s, a, 4'hF, 32'h0);
      for (int i = 0; i < 4 && rvalid !== 1'b1; i++) begin
         @(posedge clk_in);
         #1;
      end
      chk({31'h0, rvalid}, 32'h1, "no answer");
      chk(rdata, e, "read data");
   endtask
   task automatic pulse(input int i);
      @(posedge clk_in);
      #1 evt = 9'(1 << i);
      @(posedge clk_in);
      #1 evt = '0;
      es |= 32'h1 << evb[i];
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      #100000 mismatches++;
      final_report();
   end
   initial begin
      for (int i = 0; i < 1024; i++) em[i] = 32'h0;
      repeat (10) @(posedge clk_in);
      #1 resetn_in = 1'b1;
      por_n = 1'b1;
      rd(1'b0, 12'h0F8, 32'h0);
      rd(1'b0, 12'h104, 32'h0);
      send(1'b1, 1'b0, 12'h100, 4'hF, 32'hFFFF_FFFF);
      rd(1'b0, 12'h100, {ecw_pkg::NEXT_PTR_RST, 4'h1, 16'h0001});
      $display("header test done");
      for (int k = 0; k < 6; k++) begin
         v = rnd();
         if (v[11:0] >= 12'h0F8 && v[11:0] < 12'h108) v[11] = 1'b1;
         t = v[11:0] & 12'hFFC;
         send(1'b1, 1'b0, 12'h0F8, 4'hF, v);
         chk(waddr, v & 32'h0000_0FFC, "window address");
         d = rnd();
         w = rnd();
         send(1'b1, 1'b0, 12'h0FC, d[3:0], w);
         chk({31'h0, fwd.valid}, 32'h1, "fwd valid");
         chk({31'h0, fwd.write}, 32'h1, "fwd write");
         chk(fwd.wdata, w, "fwd data");
         chk({20'h0, fwd.addr}, {20'h0, t}, "fwd addr");
         chk({28'h0, fwd.be}, {28'h0, d[3:0]}, "fwd be");
         for (int b = 0; b < 4; b++)
            if (d[b]) em[t[11:2]][8*b+:8] = w[8*b+:8];
         rd(1'b0, 12'h0FC, em[t[11:2]]);
      end
      send(1'b1, 1'b1, 12'h0FC, 4'hF, rnd());
      chk({31'h0, fwd.valid}, 32'h0, "smbus write forwarded");
      rd(1'b1, 12'h0FC, 32'h0);
      rd(1'b0, 12'h0FC, em[t[11:2]]);
      send(1'b1, 1'b0, 12'h0F8, 4'hF, 32'h0000_00FC);
      send(1'b1, 1'b0, 12'h0FC, 4'hF, rnd());
      chk({31'h0, fwd.valid}, 32'h0, "self write forwarded");
      rd(1'b0, 12'h0FC, 32'h0);
      chk(waddr, 32'h0000_00FC, "self write changed window");
      $display("window test done");
      for (int i = 0; i < 9; i++) begin
         pulse(i);
         chk(stat, es, "event status");
      end
      rd(1'b0, 12'h104, es);
      send(1'b1, 1'b0, 12'h104, 4'hF, 32'h0000_0010);
      es &= ~32'h10;
      chk(stat, es, "one bit clear");
      resetn_in = 1'b0;
      repeat (2) @(posedge clk_in);
      #1 chk(waddr, 32'h0, "window after reset");
      chk(stat, es, "status kept over reset");
      resetn_in = 1'b1;
      send(1'b1, 1'b0, 12'h104, 4'hF, 32'hFFFF_FFFF);
      es = 32'h0;
      chk(stat, es, "all clear");
      pulse(8);
      por_n = 1'b0;
      #20 chk(stat, 32'h0, "power-on clears");
      por_n = 1'b1;
      $display("status test done");
      final_report();
   end
endmodule
`default_nettype wire
